// [src/txd_handler.sv]
// transmit descriptor handler: ring walk, ownership hand-off, chaining
`timescale 1ns/1ns
// Function
// - each descriptor is four words, all fetched
// - word0 bit 15 set means device owns
// - release only after far-end acknowledgement
// - released descriptor fields never modified
// - host/iop select bit is ignored
// - first and last together means no chaining
// - japan mode copies bits 11:10 to priority
// - upper address byte never altered by device
// - length used only first descriptor, option clear
// - signal unit length is positive octet count
// - octet count word is two's complement
module txd_handler
(
   input  wire logic               clk_sys,
   input  wire logic               nrst,
   input  wire logic               tx_enable,
   input  wire logic [23:0]        ring_base,
   input  wire logic [7:0]         ring_last_index,
   input  wire logic               japan_mode_enable,
   input  wire logic               data_count_option,
   output      logic               mem_req,
   output      logic               mem_we,
   output      logic [23:0]        mem_addr,
   output      logic [15:0]        mem_wdata,
   input  wire logic               mem_ack,
   input  wire logic [15:0]        mem_rdata,
   output      logic               buf_valid,
   input  wire logic               buf_ready,
   output      txd_pkg::txd_buf_t  buf_info,
   input  wire logic               far_ack,
   output      logic [7:0]         ring_index,
   output      logic               chain_error
);
   import txd_pkg::*;

   txd_regs_t q;
   txd_regs_t d;

   logic [15:0] w0;
   logic        w0_first;
   logic        w0_last;

   assign w0       = q.tx_descriptor_word0;
   assign w0_first = w0[FIRST_BIT];
   assign w0_last  = w0[LAST_BIT];

   // ==========================================================
   // shared memory access
   // word address = base + descriptor offset + word offset (bytes)
   assign mem_req  = (q.st == ST_POLL) || (q.st == ST_FETCH) ||
                     (q.st == ST_RELEASE);
   assign mem_we   = (q.st == ST_RELEASE);
   assign mem_addr = ring_base
                   + {13'h0000, q.idx, 3'h0}
                   + {21'h000000, q.widx, 1'h0};
   // only the ownership bit drops; every other bit goes back as read,
   // so the upper address byte and the select bit survive untouched
   assign mem_wdata = {1'b0, w0[OWN_BIT-1:0]};

   // ==========================================================
   // buffer offer towards the transmitter
   assign buf_valid = (q.st == ST_OFFER);
   // decode is combinational from the held words, so it stands with the offer
   always_comb begin
      buf_info = '0;
      buf_info.tx_buffer_address =
         {w0[ADDR_HI_MSB:ADDR_HI_LSB], q.tx_descriptor_word1};
      // host stores the count negated; hand the transmitter a plain count
      buf_info.buffer_octet_count =
         16'h0000 - q.tx_descriptor_word3;
      buf_info.su_len_valid = w0_first && !data_count_option;
      buf_info.signal_unit_length =
         buf_info.su_len_valid ? q.tx_descriptor_word2 : WORD_RST;
      buf_info.first_buffer_flag = w0_first;
      buf_info.last_buffer_flag  = w0_last;
      buf_info.chained = !(w0_first && w0_last);
      buf_info.priority_indication = japan_mode_enable ?
         w0[PRIO_HI:PRIO_LO] : PRIO_NONE;
   end

   assign ring_index  = q.idx;
   assign chain_error = q.chain_err;

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      // chain_error is a one-cycle pulse; whoever watches it must latch it
      d.chain_err = 1'b0;
      case (q.st)
         ST_IDLE: begin
            // a refused poll rests here for a cycle before the next look
            if (tx_enable) begin
               d.st   = ST_POLL;
               d.widx = WIDX_FIRST;
            end
         end
         ST_POLL: begin
            if (mem_ack) begin
               d.tx_descriptor_word0 = mem_rdata;
               // bit 14 is deliberately not looked at here
               if (mem_rdata[OWN_BIT]) begin
                  d.st   = ST_FETCH;
                  d.widx = WIDX_ADDR_LO;
                  // a stray first flag mid-chain, or a missing one at the
                  // start, is reported but the buffer is still sent
                  d.chain_err = (mem_rdata[FIRST_BIT] == q.in_chain);
               end else begin
                  // not ours yet: drop back and poll again later
                  d.st = ST_IDLE;
               end
            end
         end
         ST_FETCH: begin
            if (mem_ack) begin
               case (q.widx)
                  WIDX_ADDR_LO: d.tx_descriptor_word1 = mem_rdata;
                  WIDX_SU_LEN:  d.tx_descriptor_word2 = mem_rdata;
                  default:      d.tx_descriptor_word3 = mem_rdata;
               endcase
               if (q.widx == WIDX_LAST) begin
                  d.st = ST_OFFER;
               end else begin
                  d.widx = q.widx + 2'h1;
               end
            end
         end
         ST_OFFER: begin
            // far_ack is not looked at here: an early one is simply lost
            if (buf_ready) begin
               d.st = ST_WAIT_ACK;
            end
         end
         ST_WAIT_ACK: begin
            // end of transmission alone is not enough to hand back
            if (far_ack) begin
               d.st   = ST_RELEASE;
               d.widx = WIDX_FIRST;
            end
         end
         ST_RELEASE: begin
            // the next entry is only read once this write lands, so a
            // chained unit can never be offered out of ring order
            if (mem_ack) begin
               d.st       = ST_IDLE;
               d.in_chain = !w0_last;
               d.idx      = (q.idx == ring_last_index) ?
                            IDX_RST : q.idx + 8'h01;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state register
   // reset leaves an idle handler holding an empty, unowned descriptor
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         q.st                  <= ST_IDLE;
         q.widx                <= WIDX_FIRST;
         q.idx                 <= IDX_RST;
         q.in_chain            <= 1'b0;
         q.chain_err           <= 1'b0;
         q.tx_descriptor_word0 <= WORD_RST;
         q.tx_descriptor_word1 <= WORD_RST;
         q.tx_descriptor_word2 <= WORD_RST;
         q.tx_descriptor_word3 <= WORD_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // assertions
   a_release_needs_ack: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      $rose(mem_we) |-> $past(far_ack) && $past(q.st == ST_WAIT_ACK))
      else $error("descriptor released without far-end acknowledgement");

   a_release_keeps_fields: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (mem_req && mem_we) |-> (mem_wdata[14:0] == w0[14:0]) &&
         (mem_addr == ring_base + {13'h0000, q.idx, 3'h0}))
      else $error("release write alters descriptor fields");

   a_offer_owned_only: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      buf_valid |-> w0[OWN_BIT] && !mem_wdata[OWN_BIT])
      else $error("buffer offered from a descriptor not owned");

   a_four_word_fetch: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      $rose(buf_valid) |-> $past(q.widx) == WIDX_LAST &&
                           $past(q.st) == ST_FETCH && $past(mem_ack))
      else $error("buffer offered before all four words were read");

   a_octet_negated: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      buf_valid |->
         (buf_info.buffer_octet_count + q.tx_descriptor_word3) == 16'h0000)
      else $error("octet count not taken as two's complement");

   a_address_join: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      buf_valid |-> buf_info.tx_buffer_address[23:16] == w0[7:0] &&
                    buf_info.tx_buffer_address[15:0] ==
                    q.tx_descriptor_word1)
      else $error("buffer address not formed from words 0 and 1");

   a_length_gated: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      buf_valid && (!w0_first || data_count_option) |->
         !buf_info.su_len_valid && buf_info.signal_unit_length == 16'h0000)
      else $error("signal unit length used outside first descriptor");

   a_priority_copy: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      buf_valid && japan_mode_enable |->
         buf_info.priority_indication == w0[11:10])
      else $error("priority bits not copied in japan mode");

   a_single_no_chain: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      mem_we && mem_ack && w0_first && w0_last |=> !q.in_chain)
      else $error("single buffer unit left the chain open");

   a_chain_advance: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      mem_we && mem_ack && !w0_last && q.idx != ring_last_index |=>
         q.in_chain && q.idx == $past(q.idx) + 8'h01)
      else $error("chain did not move to the next descriptor");

   // ==========================================================
   // ordering and hand-off checks
   a_poll_first_word: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (q.st == ST_POLL) |-> !mem_we && (q.widx == WIDX_FIRST))
      else $error("ownership poll does not read the first word");

   a_owner_decides: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (q.st == ST_POLL) && mem_ack |=>
         (q.st == ST_FETCH) == $past(mem_rdata[OWN_BIT]))
      else $error("fetch decision not taken from the ownership bit");

   a_fetch_in_order: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (q.st == ST_FETCH) && mem_ack && (q.widx != WIDX_LAST) |=>
         (q.st == ST_FETCH) && (q.widx == $past(q.widx) + 2'h1))
      else $error("descriptor words not fetched in order");

   // the memory may stall for any number of cycles; nothing may move
   a_request_held: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
                              $stable(mem_we) && $stable(mem_wdata))
      else $error("memory request changed before acknowledge");

   // an acknowledge before the offer is taken is dropped, not remembered
   a_early_ack_dropped: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (q.st == ST_OFFER) && far_ack |=> (q.st != ST_RELEASE))
      else $error("acknowledge taken before the offer was accepted");

   a_write_owned_only: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      mem_we |-> mem_req && w0[OWN_BIT] && (q.widx == WIDX_FIRST))
      else $error("device writes a descriptor it does not hold");

   // limitation: the mode inputs must not move while an offer stands
   a_offer_stands: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      buf_valid && !buf_ready |=> buf_valid && $stable(buf_info))
      else $error("buffer offer changed before it was taken");

   a_addr_byte_kept: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      mem_we |-> mem_wdata[ADDR_HI_MSB:ADDR_HI_LSB] ==
                 buf_info.tx_buffer_address[23:16])
      else $error("release write alters the upper address byte");

   a_index_wrap: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      mem_we && mem_ack && (q.idx == ring_last_index) |=>
         (q.idx == IDX_RST) && (q.st == ST_IDLE))
      else $error("ring index did not wrap after the last entry");

   a_error_cause: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      chain_error |-> $past(q.st == ST_POLL) && $past(mem_ack) &&
                      $past(mem_rdata[OWN_BIT]))
      else $error("chain error raised outside an owned poll");

endmodule

// [src/txd_pkg.sv]
// package: descriptor layout, types and states of the transmit descriptor handler
package txd_pkg;

   // ==========================================================
   // descriptor geometry
   localparam int unsigned DESC_WORDS    = 4;
   localparam int unsigned WORD_BYTES_SH = 1;
   localparam int unsigned DESC_BYTES_SH = 3;
   localparam logic [1:0]  WIDX_FIRST    = 2'h0;
   localparam logic [1:0]  WIDX_ADDR_LO  = 2'h1;
   localparam logic [1:0]  WIDX_SU_LEN   = 2'h2;
   localparam logic [1:0]  WIDX_LAST     = 2'h3;

   // ==========================================================
   // first descriptor word fields
   localparam int unsigned OWN_BIT      = 15;
   localparam int unsigned SELECT_BIT   = 14;
   localparam int unsigned FIRST_BIT    = 13;
   localparam int unsigned LAST_BIT     = 12;
   localparam int unsigned PRIO_HI      = 11;
   localparam int unsigned PRIO_LO      = 10;
   localparam int unsigned ADDR_HI_MSB  = 7;
   localparam int unsigned ADDR_HI_LSB  = 0;

   // ==========================================================
   // reset values
   localparam logic [15:0] WORD_RST     = 16'h0000;
   localparam logic [7:0]  IDX_RST      = 8'h00;
   localparam logic [1:0]  PRIO_NONE    = 2'h0;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_POLL,
      ST_FETCH,
      ST_OFFER,
      ST_WAIT_ACK,
      ST_RELEASE
   } txd_state_t;

   typedef struct packed {
      logic [23:0] tx_buffer_address;
      logic [15:0] buffer_octet_count;
      logic [15:0] signal_unit_length;
      logic        su_len_valid;
      logic        first_buffer_flag;
      logic        last_buffer_flag;
      logic        chained;
      logic [1:0]  priority_indication;
   } txd_buf_t;

   typedef struct packed {
      txd_state_t  st;
      logic [1:0]  widx;
      logic [7:0]  idx;
      logic        in_chain;
      logic        chain_err;
      logic [15:0] tx_descriptor_word0;
      logic [15:0] tx_descriptor_word1;
      logic [15:0] tx_descriptor_word2;
      logic [15:0] tx_descriptor_word3;
   } txd_regs_t;

endpackage

// [dv/txd_mem_model.sv]
// shared memory model standing for the host side of the descriptor ring
`timescale 1ns/1ns
module txd_mem_model
(
   input  wire logic        clk_sys,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output      logic        mem_ack,
   output      logic [15:0] mem_rdata
);
   // ==========================================================
   // storage: sixteen four-word entries, word n at base+8i+2n
   logic [15:0] mem [0:63];
   logic [1:0]  wait_q = 2'h0;
   logic [15:0] last_q = 16'h0000;
   // the bench puts the ring at 24'h012300; other pages get no answer
   localparam logic [16:0] RING_PAGE = 17'h00246;

   // same-cycle answer, or a two-cycle stall when slow
   assign mem_ack = mem_req && (mem_addr[23:7] == RING_PAGE) &&
                    (!slow || wait_q == 2'h2);
   // undriven read bus shows the inverse of the last word, not a stale copy
   assign mem_rdata = mem_ack ? mem[mem_addr[6:1]] : ~last_q;

   always @(posedge clk_sys) begin
      wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      if (mem_ack) begin
         last_q <= mem_rdata;
      end
      if (mem_ack && mem_we) begin
         mem[mem_addr[6:1]] <= mem_wdata;
      end
   end
endmodule

// [dv/test_txd_handler.sv]
// testbench: transmit descriptor handler against the shared memory model
`timescale 1ns/1ns
module test_txd_handler;
   import txd_pkg::*;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        tx_enable = 1'b0;
   logic        japan = 1'b0;
   logic        dco = 1'b0;
   logic        slow = 1'b0;
   logic        buf_ready = 1'b0;
   logic        far_ack = 1'b0;
   logic        ce_seen = 1'b0;
   logic        mem_req, mem_we, mem_ack, buf_valid, chain_error;
   logic [23:0] mem_addr;
   logic [15:0] mem_wdata, mem_rdata;
   logic [7:0]  ring_index;
   txd_buf_t    buf_info;
   int          err_count = 0;
   int          cmp_count = 0;

   always #50 clk_sys = ~clk_sys;
   // the error flag is a single-cycle pulse, so latch it
   always @(posedge clk_sys) if (chain_error === 1'b1) ce_seen <= 1'b1;

   txd_handler uut (.clk_sys(clk_sys), .nrst(nrst), .tx_enable(tx_enable),
      .ring_base(24'h012300), .ring_last_index(8'h03),
      .japan_mode_enable(japan), .data_count_option(dco),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_info(buf_info),
      .far_ack(far_ack), .ring_index(ring_index),
      .chain_error(chain_error));

   txd_mem_model mem_m (.clk_sys(clk_sys), .slow(slow), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // ==========================================================
   // reporting
   task automatic end_of_test;
      $display("errors=%0d compares=%0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_b(input txd_buf_t got, input txd_buf_t exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic timed_out;
      cmp_v(16'h0000, 16'h0001);
      end_of_test();
   endtask

   // ==========================================================
   // host side: buffer words first, ownership word last
   task automatic set_desc(input logic [3:0] i,
                           input logic [15:0] w0, w1, w2, w3);
      @(negedge clk_sys);
      mem_m.mem[{i, 2'h1}] = w1;
      mem_m.mem[{i, 2'h2}] = w2;
      mem_m.mem[{i, 2'h3}] = w3;
      mem_m.mem[{i, 2'h0}] = w0;
   endtask

   // offer, early far_ack that must be ignored, take, late ack, release
   task automatic run_desc(input logic [3:0] i, input txd_buf_t exp);
      logic [15:0] w0;
      int          n;
      w0 = mem_m.mem[{i, 2'h0}];
      n = 0;
      do begin @(negedge clk_sys); n++; end
      while (buf_valid !== 1'b1 && n < 300);
      if (n >= 300) timed_out();
      cmp_b(buf_info, exp);
      @(posedge clk_sys) far_ack <= 1'b1;
      @(posedge clk_sys) begin far_ack <= 1'b0; buf_ready <= 1'b1; end
      @(posedge clk_sys) buf_ready <= 1'b0;
      repeat (4) @(negedge clk_sys);
      cmp_v(mem_m.mem[{i, 2'h0}], w0);
      @(posedge clk_sys) far_ack <= 1'b1;
      @(posedge clk_sys) far_ack <= 1'b0;
      n = 0;
      while (mem_m.mem[{i, 2'h0}][15] !== 1'b0 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 300) timed_out();
      cmp_v(mem_m.mem[{i, 2'h0}], w0 & 16'h7FFF);
   endtask

   // ==========================================================
   // scenarios
   task automatic s_single;
      run_desc(4'h0, txd_buf_t'{24'h123456, 16'h000A, 16'h0005,
         1'b1, 1'b1, 1'b1, 1'b0, 2'h0});
      cmp_v({8'h00, ring_index}, 16'h0001);
   endtask

   task automatic s_chain;
      @(posedge clk_sys) begin japan <= 1'b1; dco <= 1'b1; end
      run_desc(4'h1, txd_buf_t'{24'h010010, 16'h0002, 16'h0000,
         1'b0, 1'b1, 1'b0, 1'b1, 2'h2});
      run_desc(4'h2, txd_buf_t'{24'h020020, 16'h0004, 16'h0000,
         1'b0, 1'b0, 1'b1, 1'b1, 2'h3});
      cmp_v({8'h00, ring_index}, 16'h0003);
      cmp_v({15'h0000, ce_seen}, 16'h0000);
   endtask

   task automatic s_unowned_wrap;
      int n;
      n = 0;
      @(posedge clk_sys) slow <= 1'b1;
      repeat (20) begin
         @(negedge clk_sys);
         if (buf_valid !== 1'b0) n++;
      end
      cmp_v(n[15:0], 16'h0000);
      cmp_v({8'h00, ring_index}, 16'h0003);
      set_desc(4'h3, 16'h90AB, 16'h0002, 16'h0007, 16'hFFFF);
      run_desc(4'h3, txd_buf_t'{24'hAB0002, 16'h0001, 16'h0000,
         1'b0, 1'b0, 1'b1, 1'b1, 2'h0});
      cmp_v({15'h0000, ce_seen}, 16'h0001);
      cmp_v({8'h00, ring_index}, 16'h0000);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      set_desc(4'h0, 16'hB012, 16'h3456, 16'h0005, 16'hFFF6);
      set_desc(4'h1, 16'hE801, 16'h0010, 16'h0009, 16'hFFFE);
      set_desc(4'h2, 16'h9C02, 16'h0020, 16'h0000, 16'hFFFC);
      set_desc(4'h3, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp_v({8'h00, ring_index}, 16'h0000);
      cmp_v({15'h0000, buf_valid}, 16'h0000);
      @(posedge clk_sys) begin nrst <= 1'b1; tx_enable <= 1'b1; end
      s_single();
      s_chain();
      s_unowned_wrap();
      end_of_test();
   end
endmodule
